// ---- logic/mts_params.svh ----
// Offsets, field positions, reset values and timing counts of the trigger sequencer.
`ifndef MTS_PARAMS_SVH
`define MTS_PARAMS_SVH

`define MTS_A_CTRL 8'h00
`define MTS_A_TCNT 8'h04
`define MTS_A_SCNT 8'h08
`define MTS_A_DLY 8'h0C
`define MTS_A_CMD 8'h10
`define MTS_A_STAT 8'h14
`define MTS_A_BUF 8'h18
`define MTS_A_LVL 8'h1C

`define MTS_CTRL_AUTO 6
`define MTS_CTRL_AC 7
`define MTS_CTRL_SHORT 8

`define MTS_CMD_MEAS 0
`define MTS_CMD_CONF 1
`define MTS_CMD_INIT 2
`define MTS_CMD_ABORT 3
`define MTS_CMD_SST 4
`define MTS_CMD_SYS 5

`define MTS_STAT_ERR 2
`define MTS_STAT_IGN 3
`define MTS_STAT_OVF 4

`define MTS_SRC_BUS 3'h0
`define MTS_SRC_EXT 3'h1
`define MTS_SRC_HOLD 3'h2
`define MTS_SRC_IMM 3'h3
`define MTS_SRC_BP 3'h4

`define MTS_CNT_ONE 24'h00_0001
`define MTS_CNT_MAX 24'hFF_FFFF
`define MTS_DLY_ZERO 24'h00_0000
`define MTS_ERR_OUT_OF_MEM 16'h03E8

`define MTS_BUF_DEPTH 512
`define MTS_CAP_SHORT 10'h200
`define MTS_CAP_LONG 10'h100

`define MTS_CLK_PERIOD_NS 25
`define MTS_US_NS 1000
`define MTS_CYC_PER_US (`MTS_US_NS / `MTS_CLK_PERIOD_NS)
`define MTS_AC_DELAY_MS 500
`define MTS_AC_DELAY_US (`MTS_AC_DELAY_MS * 1000)

`endif

// ---- logic/mts_pkg.sv ----
// Types shared by the trigger sequencer.
`include "mts_params.svh"
package mts_pkg;
  typedef enum logic [1:0] {mts_st_idle, mts_st_wait, mts_st_trigd} mts_state_t;
  typedef enum logic [2:0] {
    mts_src_bus = `MTS_SRC_BUS,
    mts_src_ext = `MTS_SRC_EXT,
    mts_src_hold = `MTS_SRC_HOLD,
    mts_src_imm = `MTS_SRC_IMM,
    mts_src_bp = `MTS_SRC_BP
  } mts_src_t;
endpackage

// ---- logic/mts_trigger_sequencer.sv ----
// Measurement trigger sequencer with register port and reading buffer.
`timescale 1ns/10ps
`include "mts_params.svh"
module mts_trigger_sequencer #(
  parameter logic [23:0] AC_AUTO_DELAY_US = 24'(`MTS_AC_DELAY_US)
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic bus_get,
  input wire logic last_listener,
  input wire logic ext_trig_n,
  input wire logic [7:0] bp_trig_n,
  output logic meas_start,
  input wire logic meas_done,
  input wire logic [15:0] meas_data,
  output logic [1:0] seq_state,
  output logic err_out_of_mem
);

  localparam logic [5:0] PRESC_LAST = 6'(`MTS_CYC_PER_US - 1);

  mts_pkg::mts_state_t state_ff;
  mts_pkg::mts_state_t nxt_state;
  mts_pkg::mts_src_t cfg_src_ff;
  logic [2:0] cfg_bp_ff;
  logic cfg_auto_ff;
  logic cfg_ac_ff;
  logic cfg_short_ff;
  logic [23:0] tcnt_ff;
  logic [23:0] scnt_ff;
  logic [23:0] dly_ff;
  logic [23:0] trig_left_ff;
  logic [23:0] samp_left_ff;
  logic [23:0] dly_us_ff;
  logic [5:0] presc_ff;
  logic busy_ff;
  logic meas_start_ff;
  logic err_ff;
  logic ign_ff;
  logic ovf_ff;
  logic ext_prev_ff;
  logic [7:0] bp_prev_ff;
  logic [15:0] mem_ff [`MTS_BUF_DEPTH];
  logic [8:0] wptr_ff;
  logic [8:0] rptr_ff;
  logic [9:0] lvl_ff;
  logic [31:0] rdata_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode and commands.

  wire is_idle = (state_ff == mts_pkg::mts_st_idle);
  wire is_wait = (state_ff == mts_pkg::mts_st_wait);
  wire is_trigd = (state_ff == mts_pkg::mts_st_trigd);
  wire wr_ctrl = wr && (addr == `MTS_A_CTRL) && is_idle;
  wire wr_tcnt = wr && (addr == `MTS_A_TCNT) && is_idle;
  wire wr_scnt = wr && (addr == `MTS_A_SCNT) && is_idle;
  wire wr_dly = wr && (addr == `MTS_A_DLY) && is_idle;
  wire wr_stat = wr && (addr == `MTS_A_STAT);
  wire cmd_w = wr && (addr == `MTS_A_CMD);
  wire cmd_meas = cmd_w && wdata[`MTS_CMD_MEAS];
  wire cmd_conf = cmd_w && wdata[`MTS_CMD_CONF];
  wire cmd_init = cmd_w && wdata[`MTS_CMD_INIT];
  wire cmd_abort = cmd_w && wdata[`MTS_CMD_ABORT];
  wire cmd_sst = cmd_w && wdata[`MTS_CMD_SST];
  wire cmd_sys = cmd_w && wdata[`MTS_CMD_SYS];
  wire do_conf = (cmd_meas || cmd_conf) && is_idle;
  wire arm = (cmd_meas || cmd_init) && is_idle;
  wire pop = rd && (addr == `MTS_A_BUF) && (lvl_ff != 10'h000);

  // A count of zero is outside the range and is raised to one.
  wire [23:0] cnt_in = (wdata[23:0] == 24'h00_0000) ? `MTS_CNT_ONE : wdata[23:0];
  wire cnt_is_max = (wdata[23:0] == `MTS_CNT_MAX);
  wire err_set = (wr_tcnt || wr_scnt) && cnt_is_max;

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger sources.

  wire [7:0] bp_fall;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bp
      assign bp_fall[gi] = bp_prev_ff[gi] && !bp_trig_n[gi];
    end
  endgenerate

  wire ext_fall = ext_prev_ff && !ext_trig_n;
  wire bus_evt = (bus_get && last_listener) || cmd_sys;
  wire src_bus = (cfg_src_ff == mts_pkg::mts_src_bus);
  wire src_hold = (cfg_src_ff == mts_pkg::mts_src_hold);
  wire trig_hit =
    src_bus ? bus_evt :
    (cfg_src_ff == mts_pkg::mts_src_ext) ? ext_fall :
    src_hold ? cmd_sst :
    (cfg_src_ff == mts_pkg::mts_src_imm) ? 1'b1 :
    (cfg_src_ff == mts_pkg::mts_src_bp) ? bp_fall[cfg_bp_ff] : 1'b0;
  wire abort_ok = is_wait && cmd_abort && (src_bus || src_hold);
  wire take_trig = is_wait && trig_hit && !abort_ok;
  // A bus or single trigger outside waiting is dropped and flagged.
  wire ign_set = !is_wait && ((src_bus && bus_evt) || (src_hold && cmd_sst));

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencing: trigger loop outside, sample loop inside.

  wire meas_fin = busy_ff && meas_done;
  wire last_samp = meas_fin && (samp_left_ff == `MTS_CNT_ONE);
  wire last_trig = (trig_left_ff == `MTS_CNT_ONE);
  wire dly_done = (dly_us_ff == `MTS_DLY_ZERO);
  wire start_go = is_trigd && dly_done && !busy_ff && !meas_start_ff;
  wire presc_wrap = (presc_ff == PRESC_LAST);
  // Explicit delays on AC are raised to at least the AC minimum.
  wire [23:0] dly_min = cfg_ac_ff ? AC_AUTO_DELAY_US : `MTS_DLY_ZERO;
  wire [23:0] eff_dly = cfg_auto_ff ? dly_min :
                        (dly_ff < dly_min) ? dly_min : dly_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      mts_pkg::mts_st_idle: begin
        if (arm) begin
          nxt_state = mts_pkg::mts_st_wait;
        end
      end
      mts_pkg::mts_st_wait: begin
        if (abort_ok) begin
          nxt_state = mts_pkg::mts_st_idle;
        end else if (trig_hit) begin
          nxt_state = mts_pkg::mts_st_trigd;
        end
      end
      mts_pkg::mts_st_trigd: begin
        if (last_samp && last_trig) begin
          nxt_state = mts_pkg::mts_st_idle;
        end else if (last_samp) begin
          nxt_state = mts_pkg::mts_st_wait;
        end
      end
      default: begin
        nxt_state = mts_pkg::mts_st_idle;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_ff <= mts_pkg::mts_st_idle;
      trig_left_ff <= `MTS_CNT_ONE;
      samp_left_ff <= `MTS_CNT_ONE;
    end else if (ce) begin
      state_ff <= nxt_state;
      if (arm) begin
        trig_left_ff <= do_conf ? `MTS_CNT_ONE : tcnt_ff;
      end else if (last_samp) begin
        trig_left_ff <= trig_left_ff - 24'h00_0001;
      end
      if (take_trig) begin
        samp_left_ff <= scnt_ff;
      end else if (meas_fin) begin
        samp_left_ff <= samp_left_ff - 24'h00_0001;
      end
    end
  end

  // Delay counts microseconds; the prescaler divides the clock down to 1 us.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dly_us_ff <= `MTS_DLY_ZERO;
      presc_ff <= 6'h00;
      busy_ff <= 1'b0;
      meas_start_ff <= 1'b0;
    end else if (ce) begin
      meas_start_ff <= start_go;
      if (start_go) begin
        busy_ff <= 1'b1;
      end else if (meas_fin) begin
        busy_ff <= 1'b0;
      end
      if (take_trig) begin
        dly_us_ff <= eff_dly;
        presc_ff <= 6'h00;
      end else if (is_trigd && !dly_done) begin
        presc_ff <= presc_wrap ? 6'h00 : presc_ff + 6'h01;
        if (presc_wrap) begin
          dly_us_ff <= dly_us_ff - 24'h00_0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cfg_src_ff <= mts_pkg::mts_src_imm;
      cfg_bp_ff <= 3'h0;
      cfg_auto_ff <= 1'b1;
      cfg_ac_ff <= 1'b0;
      cfg_short_ff <= 1'b0;
      tcnt_ff <= `MTS_CNT_ONE;
      scnt_ff <= `MTS_CNT_ONE;
      dly_ff <= `MTS_DLY_ZERO;
    end else if (ce) begin
      if (do_conf) begin
        cfg_src_ff <= mts_pkg::mts_src_imm;
        cfg_auto_ff <= 1'b1;
        tcnt_ff <= `MTS_CNT_ONE;
        scnt_ff <= `MTS_CNT_ONE;
      end else begin
        if (wr_ctrl) begin
          cfg_src_ff <= mts_pkg::mts_src_t'(wdata[2:0]);
          cfg_bp_ff <= wdata[5:3];
          cfg_auto_ff <= wdata[`MTS_CTRL_AUTO];
          cfg_ac_ff <= wdata[`MTS_CTRL_AC];
          cfg_short_ff <= wdata[`MTS_CTRL_SHORT];
        end else if (wr_dly) begin
          cfg_auto_ff <= 1'b0;
        end
        if (wr_tcnt) begin
          tcnt_ff <= cnt_in;
        end
        if (wr_scnt) begin
          scnt_ff <= cnt_in;
        end
      end
      if (wr_dly) begin
        dly_ff <= wdata[23:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky flags; a set in the clearing cycle wins.

  wire [9:0] buf_cap = cfg_short_ff ? `MTS_CAP_SHORT : `MTS_CAP_LONG;
  wire buf_room = (lvl_ff < buf_cap);
  wire push = meas_fin && buf_room;
  wire ovf_set = meas_fin && !buf_room;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      err_ff <= 1'b0;
      ign_ff <= 1'b0;
      ovf_ff <= 1'b0;
      ext_prev_ff <= 1'b1;
      bp_prev_ff <= 8'hFF;
    end else if (ce) begin
      err_ff <= (err_ff && !(wr_stat && wdata[`MTS_STAT_ERR])) || err_set;
      ign_ff <= (ign_ff && !(wr_stat && wdata[`MTS_STAT_IGN])) || ign_set;
      ovf_ff <= (ovf_ff && !(wr_stat && wdata[`MTS_STAT_OVF])) || ovf_set;
      ext_prev_ff <= ext_trig_n;
      bp_prev_ff <= bp_trig_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reading buffer. Arming empties it so new readings overwrite old ones.

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wptr_ff <= 9'h000;
      rptr_ff <= 9'h000;
      lvl_ff <= 10'h000;
    end else if (ce) begin
      if (arm) begin
        wptr_ff <= 9'h000;
        rptr_ff <= 9'h000;
        lvl_ff <= 10'h000;
      end else begin
        wptr_ff <= push ? wptr_ff + 9'h001 : wptr_ff;
        rptr_ff <= pop ? rptr_ff + 9'h001 : rptr_ff;
        lvl_ff <= lvl_ff + {9'h000, push} - {9'h000, pop};
      end
    end
  end

  // Storage has no reset; the level counter says which words are valid.
  always_ff @(posedge mclk) begin
    if (ce && push) begin
      mem_ff[wptr_ff] <= meas_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port: data stand for exactly the cycle after the strobe.

  wire [31:0] ctrl_rd = {23'h00_0000, cfg_short_ff, cfg_ac_ff, cfg_auto_ff,
                         cfg_bp_ff, cfg_src_ff};
  wire [31:0] stat_rd = {11'h000, `MTS_ERR_OUT_OF_MEM & {16{err_ff}}, ovf_ff, ign_ff, err_ff,
                         state_ff};
  wire [31:0] buf_rd = (lvl_ff != 10'h000) ? {16'h0000, mem_ff[rptr_ff]} : 32'h0000_0000;
  wire [31:0] rd_mux =
    (addr == `MTS_A_CTRL) ? ctrl_rd :
    (addr == `MTS_A_TCNT) ? {8'h00, tcnt_ff} :
    (addr == `MTS_A_SCNT) ? {8'h00, scnt_ff} :
    (addr == `MTS_A_DLY) ? {8'h00, dly_ff} :
    (addr == `MTS_A_STAT) ? stat_rd :
    (addr == `MTS_A_BUF) ? buf_rd :
    (addr == `MTS_A_LVL) ? {22'h00_0000, lvl_ff} : 32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      rdata_ff <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign rdata = rdata_ff;
  assign meas_start = meas_start_ff;
  assign seq_state = state_ff;
  assign err_out_of_mem = err_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_cfg_idle;
    ce && wr && (addr == `MTS_A_TCNT) && !is_idle |=> $stable(tcnt_ff);
  endproperty
  a_cfg_idle: assert property (p_cfg_idle) else $error("count changed while active");

  property p_trig;
    ce && take_trig |=> is_trigd && samp_left_ff == $past(scnt_ff);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger not taken");

  property p_single;
    ce && last_samp && last_trig |=> is_idle;
  endproperty
  a_single: assert property (p_single) else $error("no return to idle");

  property p_stay;
    ce && meas_fin && samp_left_ff > `MTS_CNT_ONE |=> is_trigd;
  endproperty
  a_stay: assert property (p_stay) else $error("left burst early");

  property p_loop;
    ce && last_samp && !last_trig |=> is_wait && trig_left_ff == $past(trig_left_ff) - 24'h1;
  endproperty
  a_loop: assert property (p_loop) else $error("trigger loop miscounted");

  // A reading that finds the buffer full is dropped and flagged, and the level never grows.
  property p_cap;
    ce && meas_fin && !buf_room |=> ovf_ff && lvl_ff <= $past(lvl_ff);
  endproperty
  a_cap: assert property (p_cap) else $error("buffer over capacity");

  property p_hold;
    ce && is_wait && src_hold && !cmd_sst && !cmd_abort |=> is_wait;
  endproperty
  a_hold: assert property (p_hold) else $error("held source fired");

  property p_imm;
    ce && is_wait && cfg_src_ff == mts_pkg::mts_src_imm |=> is_trigd;
  endproperty
  a_imm: assert property (p_imm) else $error("always-on source did not fire");

  property p_meas;
    ce && is_idle && cmd_meas |=> is_wait && tcnt_ff == `MTS_CNT_ONE && cfg_auto_ff;
  endproperty
  a_meas: assert property (p_meas) else $error("query_a command not applied");

  property p_err;
    ce && err_set |=> err_ff;
  endproperty
  a_err: assert property (p_err) else $error("out of memory not flagged");

  property p_dly;
    ce && take_trig && eff_dly != `MTS_DLY_ZERO |=> !meas_start_ff [*2];
  endproperty
  a_dly: assert property (p_dly) else $error("delay skipped");

  property p_autoclr;
    ce && wr_dly |=> !cfg_auto_ff;
  endproperty
  a_autoclr: assert property (p_autoclr) else $error("auto delay kept");

  property p_abort;
    ce && abort_ok |=> is_idle ##1 (!ce || !is_trigd);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not honoured");

  property p_cv_burst;
    is_trigd && meas_fin ##1 is_trigd;
  endproperty
  c_cv_burst: cover property (p_cv_burst);

  property p_cv_abort;
    abort_ok && ce;
  endproperty
  c_cv_abort: cover property (p_cv_abort);

  property p_cv_ovf;
    ovf_set && ce;
  endproperty
  c_cv_ovf: cover property (p_cv_ovf);

endmodule

// ---- verification/mts_conv_model.sv ----
// Converter model that answers each start pulse after a chosen latency.
`timescale 1ns/10ps
module mts_conv_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic meas_start,
  input wire logic [7:0] lat,
  input wire logic [15:0] value,
  output logic meas_done,
  output logic [15:0] meas_data
);
  logic busy_ff;
  logic done_ff;
  logic [7:0] cnt_ff;
  logic [15:0] junk_ff;
  // Off the done pulse the data lines change every cycle, so a late sample never matches.
  assign meas_done = done_ff;
  assign meas_data = done_ff ? value : junk_ff;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      cnt_ff <= 8'h00;
      junk_ff <= 16'hc3a5;
    end else begin
      junk_ff <= {junk_ff[14:0], ~junk_ff[15]};
      done_ff <= busy_ff && cnt_ff == 8'h00;
      if (meas_start) begin
        busy_ff <= 1'b1;
        cnt_ff <= lat;
      end else if (busy_ff && cnt_ff == 8'h00) begin
        busy_ff <= 1'b0;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench of the trigger sequencer with a converter model.
`timescale 1ns/10ps
`include "mts_params.svh"
module testbench;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic bus_get = 1'b0;
  logic last_listener = 1'b0;
  logic ext_trig_n = 1'b1;
  logic [7:0] bp_trig_n = 8'hff;
  logic [7:0] lat = 8'h02;
  logic [15:0] value = 16'h0000;
  logic [31:0] rdata;
  logic meas_start;
  logic meas_done;
  logic err_out_of_mem;
  logic [15:0] meas_data;
  logic [1:0] seq_state;
  logic rd_d = 1'b0;
  logic [31:0] exp_q[$];
  int errors = 0;
  int checked = 0;
  integer seed = 32'h0000_029f;
  int n;

  always #12.5 mclk = ~mclk;

  mts_trigger_sequencer #(.AC_AUTO_DELAY_US(24'h00_0003)) mts_trigger_sequencer_inst (
    .mclk(mclk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .bus_get(bus_get), .last_listener(last_listener),
    .ext_trig_n(ext_trig_n), .bp_trig_n(bp_trig_n), .meas_start(meas_start),
    .meas_done(meas_done), .meas_data(meas_data), .seq_state(seq_state),
    .err_out_of_mem(err_out_of_mem));
  mts_conv_model mts_conv_model_inst (
    .mclk(mclk), .rstn(rstn), .meas_start(meas_start), .lat(lat), .value(value),
    .meas_done(meas_done), .meas_data(meas_data));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv, input string what);
    checked++;
    if (seen !== expv) begin
      errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, expv);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // A spare edge after each strobe keeps two calls from driving one signal in one step.
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic cmd(input int b);
    wreg(`MTS_A_CMD, 32'h0000_0001 << b);
  endtask
  // Counts edges until a start pulse is seen; 2000 means none came.
  task automatic wstart(output int c);
    c = 0;
    do begin
      @(posedge mclk);
      c++;
    end while (meas_start !== 1'b1 && c < 2000);
  endtask
  task automatic widle;
    int c;
    c = 0;
    while (seq_state !== 2'h0 && c < 8000) begin
      @(posedge mclk);
      c++;
    end
    chk(32'(c < 8000), 32'h0000_0001, "idle reached");
  endtask
  task automatic fired(input string what);
    wstart(n);
    chk(32'(n < 400), 32'h0000_0001, what);
    widle;
  endtask
  // Pulses return right after the edge that sees them, so a zero-delay start is not missed.
  task automatic pulse_bus;
    bus_get <= 1'b1;
    @(posedge mclk);
    bus_get <= 1'b0;
  endtask
  task automatic pulse_ext;
    ext_trig_n <= 1'b0;
    @(posedge mclk);
    ext_trig_n <= 1'b1;
  endtask
  task automatic pulse_bp(input int i);
    bp_trig_n[i] <= 1'b0;
    @(posedge mclk);
    bp_trig_n <= 8'hff;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) rd_d <= rd & ce;
  always @(negedge mclk) begin
    if (rd_d) begin
      chk(rdata, exp_q.pop_front(), "read data");
    end
  end

  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    give_verdict;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rreg(`MTS_A_CTRL, 32'h0000_0043);
    rreg(`MTS_A_TCNT, 32'h0000_0001);
    rreg(`MTS_A_SCNT, 32'h0000_0001);
    rreg(8'h20, 32'h0000_0000);
    $display("test reset done");
    value <= 16'($random(seed));
    lat <= 8'($random(seed)) & 8'h07;
    cmd(`MTS_CMD_MEAS);
    wstart(n);
    chk(32'(n), 32'h0000_0002, "start latency");
    chk(seq_state, 32'h0000_0002, "triggered");
    widle;
    rreg(`MTS_A_LVL, 32'h0000_0001);
    rreg(`MTS_A_BUF, {16'h0000, value});
    $display("test query_a done");
    wreg(`MTS_A_CTRL, 32'h0000_0041);
    wreg(`MTS_A_DLY, 32'h0000_0002);
    rreg(`MTS_A_CTRL, 32'h0000_0001);
    wreg(`MTS_A_TCNT, 32'h0000_0002);
    wreg(`MTS_A_SCNT, 32'h0000_0003);
    lat <= 8'h20;
    cmd(`MTS_CMD_INIT);
    wreg(`MTS_A_TCNT, 32'h0000_0005);
    rreg(`MTS_A_TCNT, 32'h0000_0002);
    for (int t = 0; t < 2; t++) begin
      pulse_ext;
      for (int s = 0; s < 3; s++) begin
        wstart(n);
        if (s > 0) chk(32'(n < 60), 32'h0000_0001, "burst spacing");
      end
      tick(50);
      chk(seq_state, t == 0 ? 32'h0000_0001 : 32'h0000_0000, "loop state");
    end
    rreg(`MTS_A_LVL, 32'h0000_0006);
    $display("test loops done");
    wreg(`MTS_A_CTRL, 32'h0000_0003);
    wreg(`MTS_A_TCNT, 32'h0000_0001);
    wreg(`MTS_A_SCNT, 32'h0000_0001);
    lat <= 8'h01;
    cmd(`MTS_CMD_INIT);
    wstart(n);
    chk(32'(n), 32'h0000_0052, "programmed delay");
    widle;
    wreg(`MTS_A_DLY, 32'h00ff_ffff);
    rreg(`MTS_A_DLY, 32'h00ff_ffff);
    wreg(`MTS_A_CTRL, 32'h0000_00c3);
    cmd(`MTS_CMD_INIT);
    wstart(n);
    chk(32'(n), 32'h0000_007a, "ac auto delay");
    widle;
    $display("test delay done");
    wreg(`MTS_A_DLY, 32'h0000_0000);
    wreg(`MTS_A_CTRL, 32'h0000_0000);
    cmd(`MTS_CMD_INIT);
    pulse_bus;
    tick(2);
    chk(seq_state, 32'h0000_0001, "unaddressed bus trigger");
    last_listener <= 1'b1;
    pulse_bus;
    fired("bus trigger");
    cmd(`MTS_CMD_INIT);
    cmd(`MTS_CMD_SYS);
    fired("system trigger");
    cmd(`MTS_CMD_INIT);
    cmd(`MTS_CMD_ABORT);
    chk(seq_state, 32'h0000_0000, "abort bus");
    cmd(`MTS_CMD_SYS);
    rreg(`MTS_A_STAT, 32'h0000_0008);
    wreg(`MTS_A_STAT, 32'h0000_001c);
    wreg(`MTS_A_CTRL, 32'h0000_0002);
    cmd(`MTS_CMD_INIT);
    pulse_ext;
    pulse_bp(0);
    tick(2);
    chk(seq_state, 32'h0000_0001, "held source");
    cmd(`MTS_CMD_SST);
    fired("single trigger");
    wreg(`MTS_A_CTRL, 32'h0000_0001);
    cmd(`MTS_CMD_INIT);
    cmd(`MTS_CMD_ABORT);
    chk(seq_state, 32'h0000_0001, "abort ext");
    pulse_ext;
    fired("ext trigger");
    for (int i = 0; i < 8; i++) begin
      wreg(`MTS_A_CTRL, 32'h0000_0004 | (i << 3));
      cmd(`MTS_CMD_INIT);
      pulse_bp((i + 1) % 8);
      tick(2);
      chk(seq_state, 32'h0000_0001, "other line");
      pulse_bp(i);
      fired("backplane line");
    end
    $display("test sources done");
    wreg(`MTS_A_STAT, 32'h0000_001c);
    lat <= 8'h00;
    wreg(`MTS_A_CTRL, 32'h0000_0003);
    wreg(`MTS_A_SCNT, 32'h0000_012c);
    cmd(`MTS_CMD_INIT);
    widle;
    rreg(`MTS_A_LVL, 32'h0000_0100);
    rreg(`MTS_A_STAT, 32'h0000_0010);
    wreg(`MTS_A_STAT, 32'h0000_001c);
    wreg(`MTS_A_CTRL, 32'h0000_0103);
    wreg(`MTS_A_SCNT, 32'h0000_0258);
    cmd(`MTS_CMD_INIT);
    widle;
    rreg(`MTS_A_LVL, 32'h0000_0200);
    $display("test buffer done");
    wreg(`MTS_A_TCNT, 32'h00ff_ffff);
    chk(err_out_of_mem, 32'h0000_0001, "out of memory");
    rreg(`MTS_A_STAT, 32'h0000_7d14);
    wreg(`MTS_A_SCNT, 32'h0000_0004);
    cmd(`MTS_CMD_CONF);
    rreg(`MTS_A_CTRL, 32'h0000_0143);
    rreg(`MTS_A_TCNT, 32'h0000_0001);
    rreg(`MTS_A_SCNT, 32'h0000_0001);
    $display("test configure done");
    ce <= 1'b0;
    wreg(`MTS_A_SCNT, 32'h0000_0009);
    ce <= 1'b1;
    rreg(`MTS_A_SCNT, 32'h0000_0001);
    $display("test clock enable done");
    give_verdict;
  end
endmodule
